/* File: core/serial_eeprom_ctrl.sv */
// instruction decoder, permission latch and self-timed program/erase engine
// of a 1 kb three-wire serial eeprom with a 128-byte array
// assumes the four link pins are asynchronous to CLK_I and the serial clock is far slower
`timescale 1ns/1ps
module serial_eeprom_ctrl
	import eeprom_cmd_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYCLES
) (
	// system
	input  wire logic CLK_I,
	input  wire logic RESET_N_I,
	// serial link pins
	input  wire logic CHIP_SELECT_I,
	input  wire logic SERIAL_CLOCK_I,
	input  wire logic SERIAL_IN_I,
	input  wire logic WIDTH_SELECT_I,
	// serial output pin
	output logic      SERIAL_OUT_O,
	output logic      SERIAL_OUT_OE_O
);

	// =========================================================
	// decoding helpers
	function automatic logic [1:0] sub_code(input logic [6:0] a, input logic x16);
		sub_code = x16 ? a[5:4] : a[6:5];
	endfunction

	function automatic logic [CNT_W-1:0] last_bit(input logic x16, input logic data);
		if (data)
			last_bit = x16 ? CNT_W'(DATA16_BITS - 1) : CNT_W'(DATA8_BITS - 1);
		else
			last_bit = x16 ? CNT_W'(HDR16_BITS - 1) : CNT_W'(HDR8_BITS - 1);
	endfunction

	// =========================================================
	// pin synchronisers and edge detection
	logic [3:0] pins_s;
	logic       cs_s, sclk_s, sdin_s, wsel_s;
	logic       cs_p_q, sclk_p_q;
	logic       sclk_rise, cs_rise, cs_fall;

	pin_sync #(.WIDTH(4)) pin_sync_i (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.pin_i     ({CHIP_SELECT_I, SERIAL_CLOCK_I, SERIAL_IN_I, WIDTH_SELECT_I}),
		.pin_o     (pins_s)
	);

	assign {cs_s, sclk_s, sdin_s, wsel_s} = pins_s;

	// previous levels for edge finding
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			cs_p_q   <= 1'b0;
			sclk_p_q <= 1'b0;
		end else begin
			cs_p_q   <= cs_s;
			sclk_p_q <= sclk_s;
		end
	end

	assign sclk_rise = cs_s && sclk_s && !sclk_p_q;
	assign cs_rise = cs_s && !cs_p_q;
	assign cs_fall = !cs_s && cs_p_q;

	// =========================================================
	// frame receiver
	frame_t             frame_q;
	logic [CNT_W-1:0]   bit_cnt_q;
	logic [15:0]        shift_q;
	logic [15:0]        shift_d;
	logic [1:0]         opc_q, opc_d;
	logic [6:0]         addr_q, addr_d;
	logic [15:0]        data_q;
	logic               x16_q;
	logic               busy_q;
	logic               hdr_done;

	assign shift_d  = {shift_q[14:0], sdin_s};
	assign hdr_done = (frame_q == FR_HEAD) && sclk_rise && (bit_cnt_q == last_bit(x16_q, 1'b0));

	// split header into opcode and address
	always_comb begin
		if (x16_q) begin
			opc_d  = shift_d[7:6];
			addr_d = {1'b0, shift_d[5:0]};
		end else begin
			opc_d  = shift_d[8:7];
			addr_d = shift_d[6:0];
		end
	end

	// frame sequencing
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			frame_q   <= FR_IDLE;
			bit_cnt_q <= '0;
			shift_q   <= '0;
			opc_q     <= OPC_READ;
			addr_q    <= '0;
			data_q    <= '0;
			x16_q     <= 1'b1;
		end else if (!cs_s) begin
			frame_q <= FR_IDLE;
		end else if (sclk_rise) begin
			case (frame_q)
				FR_IDLE: begin
					if (sdin_s && !busy_q) begin
						frame_q   <= FR_HEAD;
						bit_cnt_q <= '0;
						x16_q     <= wsel_s;
					end
				end
				FR_HEAD: begin
					shift_q   <= shift_d;
					bit_cnt_q <= bit_cnt_q + CNT_W'(1);
					if (hdr_done) begin
						opc_q     <= opc_d;
						addr_q    <= addr_d;
						bit_cnt_q <= '0;
						if (opc_d == OPC_WRITE ||
						    (opc_d == OPC_SPECIAL && sub_code(addr_d, x16_q) == SUB_FILL))
							frame_q <= FR_DATA;
						else if (opc_d == OPC_READ)
							frame_q <= FR_READ;
						else
							frame_q <= FR_DONE;
					end
				end
				FR_DATA: begin
					shift_q   <= shift_d;
					bit_cnt_q <= bit_cnt_q + CNT_W'(1);
					if (bit_cnt_q == last_bit(x16_q, 1'b1)) begin
						data_q  <= shift_d;
						frame_q <= FR_DONE;
					end
				end
				FR_READ: frame_q <= FR_READ;
				FR_DONE: frame_q <= FR_DONE;    // surplus bits ignored
				default: frame_q <= FR_IDLE;
			endcase
		end
	end

	// =========================================================
	// execution on the falling select edge
	logic       wr_en_q;
	logic       exec, start_op;
	op_t        op_sel;
	logic [1:0] sub;

	assign sub  = sub_code(addr_q, x16_q);
	// falling select ends a complete frame
	assign exec = cs_fall && (frame_q == FR_DONE) && !busy_q;

	always_comb begin
		op_sel = OP_NONE;
		case (opc_q)
			OPC_WRITE: op_sel = OP_WRITE;
			OPC_ERASE: op_sel = OP_ERASE;
			OPC_SPECIAL: begin
				if (sub == SUB_CLEAR)
					op_sel = OP_CLEAR;
				else if (sub == SUB_FILL)
					op_sel = OP_FILL;
			end
			default: op_sel = OP_NONE;
		endcase
	end

	// array operations gated by the latch
	assign start_op = exec && wr_en_q && (op_sel != OP_NONE);

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I)
			wr_en_q <= 1'b0;
		else if (exec && opc_q == OPC_SPECIAL && sub == SUB_ENABLE)
			wr_en_q <= 1'b1;
		else if (exec && opc_q == OPC_SPECIAL && sub == SUB_DISABLE)
			wr_en_q <= 1'b0;
	end

	// checks share the system clock and reset
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);

	latch_reset_a: assert property ($rose(RESET_N_I) |-> !wr_en_q)
		else $error("permission latch set after reset");
	latch_hold_a: assert property (wr_en_q
		&& !(exec && opc_q == OPC_SPECIAL && sub == SUB_DISABLE) |=> wr_en_q)
		else $error("permission latch dropped without disable");
	locked_ignore_a: assert property (!wr_en_q |-> !start_op ##1 !$rose(busy_q))
		else $error("array operation started while locked");

	// =========================================================
	// self-timed program engine
	logic [PROG_CNT_W-1:0] prog_cnt_q;
	op_t                   op_q;
	logic [6:0]            op_addr_q;
	logic [15:0]           op_data_q;
	logic                  op_x16_q;
	logic                  commit;

	assign commit = busy_q && (prog_cnt_q == '0);

	// counts on the system clock only
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			busy_q     <= 1'b0;
			prog_cnt_q <= '0;
			op_q       <= OP_NONE;
			op_addr_q  <= '0;
			op_data_q  <= '0;
			op_x16_q   <= 1'b1;
		end else if (start_op) begin
			busy_q     <= 1'b1;
			prog_cnt_q <= PROG_CNT_W'(PROG_CYC - 1);
			op_q       <= op_sel;
			op_addr_q  <= addr_q;
			op_data_q  <= data_q;
			op_x16_q   <= x16_q;
		end else if (commit) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			prog_cnt_q <= prog_cnt_q - PROG_CNT_W'(1);
		end
	end

	fall_start_a: assert property (exec && wr_en_q && opc_q == OPC_WRITE
		|=> busy_q && op_q == OP_WRITE)
		else $error("write not started on select fall");
	self_time_a: assert property (busy_q && prog_cnt_q != '0 |=> busy_q)
		else $error("timed cycle ended early");
	busy_ignore_a: assert property (busy_q |-> frame_q == FR_IDLE ##1 $stable(wr_en_q))
		else $error("instruction accepted while busy");

	// =========================================================
	// array; odd byte holds the high half of a 16-bit word
	logic [7:0] mem [BYTES];

	always_ff @(posedge CLK_I) begin
		if (commit) begin
			for (int i = 0; i < BYTES; i++) begin
				if (op_q == OP_CLEAR ||
				    op_q == OP_FILL ||
				    (op_x16_q && i[AW8-1:1] == op_addr_q[AW16-1:0]) ||
				    (!op_x16_q && i[AW8-1:0] == op_addr_q)) begin
					if (op_q == OP_ERASE || op_q == OP_CLEAR)
						mem[i] <= ERASED_BYTE;
					else if (op_x16_q && i[0])
						mem[i] <= op_data_q[15:8];
					else
						mem[i] <= op_data_q[7:0];
				end
			end
		end
	end

	erase_ones_a: assert property (commit && op_q == OP_ERASE && !op_x16_q
		|=> mem[op_addr_q] == ERASED_BYTE)
		else $error("erased byte not all ones");
	clear_all_a: assert property (commit && op_q == OP_CLEAR
		|=> mem[0] == ERASED_BYTE && mem[BYTES-1] == ERASED_BYTE)
		else $error("clear-all left a zero bit");
	fill_all_a: assert property (commit && op_q == OP_FILL
		|=> mem[BYTES-1] == (op_x16_q ? op_data_q[15:8] : op_data_q[7:0]))
		else $error("fill-all data missing");
	write_store_a: assert property (commit && op_q == OP_WRITE && !op_x16_q
		|=> mem[op_addr_q] == $past(op_data_q[7:0]))
		else $error("write data not stored");

	// =========================================================
	// read path
	logic [15:0] rd_buf_q;
	logic        rd_bit_q;
	logic        reading;

	assign reading = (frame_q == FR_READ);

	// load and shift read data, dummy zero first
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			rd_buf_q <= '0;
			rd_bit_q <= 1'b0;
		end else if (hdr_done && opc_d == OPC_READ) begin
			rd_bit_q <= 1'b0;
			if (x16_q)
				rd_buf_q <= {mem[{addr_d[AW16-1:0], 1'b1}], mem[{addr_d[AW16-1:0], 1'b0}]};
			else
				rd_buf_q <= {mem[addr_d], 8'h00};
		end else if (reading && sclk_rise) begin
			rd_bit_q <= rd_buf_q[15];
			rd_buf_q <= {rd_buf_q[14:0], 1'b0};
		end
	end

	read_free_a: assert property (hdr_done && opc_d == OPC_READ
		|=> reading ##1 SERIAL_OUT_OE_O)
		else $error("read not served");

	// =========================================================
	// ready/busy status presentation
	logic poll_q, status_q;

	// show status after a launched operation
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			poll_q   <= 1'b0;
			status_q <= 1'b0;
		end else if (start_op) begin
			poll_q   <= 1'b1;
			status_q <= 1'b0;
		end else if (!cs_s) begin
			status_q <= 1'b0;
		end else if (cs_rise && poll_q) begin
			status_q <= 1'b1;
		end else if (sclk_rise && sdin_s && !busy_q) begin
			// dummy one releases the pin, only when ready
			poll_q   <= 1'b0;
			status_q <= 1'b0;
		end
	end

	poll_show_a: assert property (cs_rise && poll_q && !start_op
		|=> status_q ##1 SERIAL_OUT_OE_O)
		else $error("status not presented on reselect");

	// output low while busy, high when ready
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			SERIAL_OUT_O    <= 1'b0;
			SERIAL_OUT_OE_O <= 1'b0;
		end else begin
			SERIAL_OUT_O    <= status_q ? !busy_q : rd_bit_q;
			SERIAL_OUT_OE_O <= status_q || reading;
		end
	end

	status_low_a: assert property (status_q && busy_q |=> SERIAL_OUT_OE_O && !SERIAL_OUT_O)
		else $error("status not low while busy");

endmodule

/* File: core/eeprom_cmd_pkg.sv */
// constants, opcodes and state types of the serial eeprom command block
// assumes a single 50 MHz system clock; nothing else is shared
package eeprom_cmd_pkg;

	// =========================================================
	// timing
	localparam int CLK_HZ       = 50_000_000;
	localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
	localparam int PROG_TIME_NS = 5_000_000;                // program/erase pulse width
	localparam int PROG_CYCLES  = PROG_TIME_NS / CLK_NS;    // longest time, rounds down
	localparam int PROG_CNT_W   = 18;

	// =========================================================
	// array and frame geometry
	localparam int BYTES        = 128;
	localparam int AW8          = 7;                        // byte address bits
	localparam int AW16         = 6;                        // word address bits
	localparam int HDR8_BITS    = 9;                        // opcode + 7 address bits
	localparam int HDR16_BITS   = 8;                        // opcode + 6 address bits
	localparam int DATA8_BITS   = 8;
	localparam int DATA16_BITS  = 16;
	localparam int CNT_W        = 5;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// =========================================================
	// opcodes and sub-codes (top two address bits of opcode 00)
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_FILL    = 2'h1;
	localparam logic [1:0] SUB_CLEAR   = 2'h2;
	localparam logic [1:0] SUB_ENABLE  = 2'h3;

	// =========================================================
	// types
	typedef enum logic [2:0] {
		FR_IDLE = 3'b000,
		FR_HEAD = 3'b001,
		FR_DATA = 3'b010,
		FR_READ = 3'b011,
		FR_DONE = 3'b100
	} frame_t;

	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_WRITE = 3'b001,
		OP_ERASE = 3'b010,
		OP_CLEAR = 3'b011,
		OP_FILL  = 3'b100
	} op_t;

endpackage

/* File: core/pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
// assumes the inputs may change at any time relative to clk_i
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] pin_o
);

	// =========================================================
	// per-bit flop pair; the first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_q;
			always_ff @(posedge clk_i) begin
				if (!reset_n_i) begin
					meta_q   <= 1'b0;
					pin_o[g] <= 1'b0;
				end else begin
					meta_q   <= pin_i[g];
					pin_o[g] <= meta_q;
				end
			end
		end
	endgenerate

endmodule

/* File: testbench/host_link_model.sv */
// host side of the three-wire link: frames, serial clock and deselect
// assumes the bench clock clk_i; one serial clock period is 8 of its cycles
`timescale 1ns/1ps
module host_link_model (
	// bench clock
	input  wire logic clk_i,
	// link pins towards the device
	output logic      chip_select_o,
	output logic      serial_clock_o,
	output logic      serial_in_o
);
	// ==========
	// idle: deselected, serial clock standing still
	initial begin
		chip_select_o  = 1'b0;
		serial_clock_o = 1'b0;
		serial_in_o    = 1'b0;
	end

	task automatic clock_bit(input logic b);
		@(negedge clk_i);
		serial_in_o = b;
		repeat (3) @(negedge clk_i);
		serial_clock_o = 1'b1;
		repeat (4) @(negedge clk_i);
		serial_clock_o = 1'b0;
		serial_in_o    = ~b; // hold over, stale value not kept
	endtask

	task automatic frame(input logic [31:0] v, input int n);
		@(negedge clk_i);
		chip_select_o = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			clock_bit(v[i]);
		end
	endtask

	task automatic select();
		@(negedge clk_i);
		chip_select_o = 1'b1;
	endtask

	task automatic deselect();
		@(negedge clk_i);
		chip_select_o = 1'b0;
		repeat (16) @(negedge clk_i);
	endtask
endmodule

/* File: testbench/serial_eeprom_command_control_tb.sv */
// self-checking bench of the serial eeprom command block
// assumes a host model drives the link; expectations come from a shadow array
`timescale 1ns/1ps
module serial_eeprom_command_control_tb;
	import eeprom_cmd_pkg::*;
	logic       clk;
	logic       reset_n;
	logic       wide;
	logic       chip_select;
	logic       serial_clock;
	logic       serial_in;
	logic       serial_out;
	logic       serial_out_oe;
	logic       serial_line;
	logic [7:0] mem [128];
	logic       en;
	logic       busy_now;
	int         fail_count;
	int         checks;
	int         cycles;

	// ==========
	// clock, design and host
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	serial_eeprom_ctrl #(.PROG_CYC(400)) serial_eeprom_ctrl_i (
		.CLK_I(clk), .RESET_N_I(reset_n), .CHIP_SELECT_I(chip_select),
		.SERIAL_CLOCK_I(serial_clock), .SERIAL_IN_I(serial_in),
		.WIDTH_SELECT_I(wide), .SERIAL_OUT_O(serial_out),
		.SERIAL_OUT_OE_O(serial_out_oe));
	host_link_model host_link_model_i (
		.clk_i(clk), .chip_select_o(chip_select),
		.serial_clock_o(serial_clock), .serial_in_o(serial_in));
	// a released output pin floats to the inverse of its last level
	assign serial_line = serial_out_oe ? serial_out : !serial_out;

	// ==========
	// helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [15:0] exp_word(input logic [6:0] a);
		return wide ? {mem[{a[5:0], 1'b1}], mem[{a[5:0], 1'b0}]} : {8'h00, mem[a]};
	endfunction

	function automatic logic [6:0] spec(input logic [1:0] sub);
		return wide ? {1'b0, sub, 4'($urandom)} : {sub, 5'($urandom)};
	endfunction

	task automatic store(input logic [6:0] a, input logic [15:0] d);
		if (wide) begin
			mem[{a[5:0], 1'b1}] = d[15:8];
			mem[{a[5:0], 1'b0}] = d[7:0];
		end else begin
			mem[a] = d[7:0];
		end
	endtask

	task automatic reset_dut();
		@(negedge clk);
		reset_n = 1'b0;
		en      = 1'b0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	task automatic poll(input logic armed);
		int n;
		host_link_model_i.select();
		repeat (8) @(negedge clk);
		check("status_oe", 16'(serial_out_oe), 16'(armed));
		if (armed) begin
			check("busy", 16'(serial_out), 16'h0000);
			n = 0;
			while (serial_out !== 1'b1 && n < 600) begin
				@(negedge clk);
				n++;
			end
			check("ready", 16'(serial_out), 16'h0001);
			host_link_model_i.clock_bit(1'b1);
			repeat (6) @(negedge clk);
			check("released", 16'(serial_out_oe), 16'h0000);
		end
		host_link_model_i.deselect();
	endtask

	// one instruction, shadow array kept in step
	task automatic send(input logic [1:0] opc, input logic [6:0] a,
			input logic [15:0] d, input logic pol);
		int          aw;
		int          dw;
		int          n;
		logic [31:0] v;
		logic [1:0]  sub;
		logic        fill;
		logic        launch;
		logic [15:0] got;
		aw = wide ? AW16 : AW8;
		dw = wide ? DATA16_BITS : DATA8_BITS;
		a = wide ? {1'b0, a[5:0]} : a;
		sub = wide ? a[5:4] : a[6:5];
		fill = (opc == OPC_SPECIAL) && (sub == SUB_FILL);
		v = ((32'h4 | opc) << aw) | a;
		n = 3 + aw;
		if (opc == OPC_WRITE || fill) begin
			v = (v << dw) | (wide ? d : {8'h00, d[7:0]});
			n = n + dw;
		end
		host_link_model_i.frame(v, n);
		if (opc == OPC_READ) begin
			repeat (3) @(negedge clk);
			check("dummy", 16'({serial_out_oe, serial_out}), 16'h0002);
			got = '0;
			for (int i = 0; i < dw; i++) begin
				host_link_model_i.clock_bit(1'b0);
				repeat (3) @(negedge clk);
				got = {got[14:0], serial_line};
			end
			check("read", got, exp_word(a));
		end
		host_link_model_i.deselect();
		launch = en && !busy_now && (opc == OPC_WRITE || opc == OPC_ERASE ||
			(opc == OPC_SPECIAL && (fill || sub == SUB_CLEAR)));
		if (opc == OPC_SPECIAL && sub == SUB_ENABLE) en = 1'b1;
		if (opc == OPC_SPECIAL && sub == SUB_DISABLE) en = 1'b0;
		if (launch) begin
			if (opc == OPC_WRITE) store(a, d);
			if (opc == OPC_ERASE) store(a, 16'hffff);
			for (int i = 0; i < 128; i++) begin
				if (opc == OPC_SPECIAL) mem[i] = fill ? (i[0] ? d[15:8] : d[7:0]) : ERASED_BYTE;
				if (opc == OPC_SPECIAL && !wide) mem[i] = fill ? d[7:0] : ERASED_BYTE;
			end
		end
		if (opc != OPC_READ && pol) poll(launch || busy_now);
	endtask

	// ==========
	// run limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			conclude();
		end
	end

	// ==========
	// scenarios
	initial begin
		logic [6:0]  a;
		logic [15:0] d;
		reset_n = 1'b0;
		wide = 1'b0;
		en = 1'b0;
		busy_now = 1'b0;
		fail_count = 0;
		checks = 0;
		cycles = 0;
		void'($urandom(8));
		reset_dut();
		send(OPC_WRITE, 7'h05, 16'h00a5, 1'b1);
		send(OPC_SPECIAL, spec(SUB_ENABLE), 16'h0000, 1'b1);
		send(OPC_SPECIAL, spec(SUB_CLEAR), 16'h0000, 1'b1);
		send(OPC_READ, 7'h7f, 16'h0000, 1'b1);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
			send(OPC_WRITE, a, 16'($urandom), 1'b1);
			send(OPC_WRITE, a, 16'($urandom), 1'b1);
			send(OPC_READ, a, 16'h0000, 1'b1);
		end
		send(OPC_ERASE, a, 16'h0000, 1'b1);
		send(OPC_READ, a, 16'h0000, 1'b1);
		send(OPC_WRITE, a, 16'h003c, 1'b0);
		busy_now = 1'b1;
		send(OPC_WRITE, a ^ 7'h01, 16'h00c3, 1'b1);
		busy_now = 1'b0;
		send(OPC_READ, a, 16'h0000, 1'b1);
		send(OPC_READ, a ^ 7'h01, 16'h0000, 1'b1);
		// disabled erase refused, reads still work
		send(OPC_SPECIAL, spec(SUB_DISABLE), 16'h0000, 1'b1);
		send(OPC_ERASE, a, 16'h0000, 1'b1);
		send(OPC_READ, a, 16'h0000, 1'b1);
		// fill all in word mode, read in both widths
		wide = 1'b1;
		d = 16'($urandom);
		send(OPC_SPECIAL, spec(SUB_ENABLE), 16'h0000, 1'b1);
		send(OPC_SPECIAL, spec(SUB_FILL), d, 1'b1);
		for (int i = 0; i < 3; i++) send(OPC_READ, 7'($urandom), 16'h0000, 1'b1);
		send(OPC_WRITE, 7'h3f, 16'($urandom), 1'b1);
		wide = 1'b0;
		send(OPC_READ, 7'h7f, 16'h0000, 1'b1);
		send(OPC_READ, 7'($urandom), 16'h0000, 1'b1);
		reset_dut();
		send(OPC_WRITE, 7'h7e, 16'h0011, 1'b1);
		send(OPC_READ, 7'h7e, 16'h0000, 1'b1);
		conclude();
	end
endmodule
